// file: hdl/bitproc_consts.vh
// Constants for the bit processor and memory move core
`ifndef BITPROC_CONSTS_VH
`define BITPROC_CONSTS_VH

`define PC_RESET 16'h0000
`define ACC_RESET 8'h00
`define STATUS_RESET 8'h00
`define DP_RESET 16'h0000
`define PORT_RESET 8'hFF
`define RAM_RESET 8'h00

`define BIT_RAM_BASE 8'h20
`define REG_PORT_ADDR 8'h90
`define REG_STATUS_ADDR 8'hD0
`define REG_ACC_ADDR 8'hE0
`define REG_DP_LO_ADDR 8'h82
`define REG_DP_HI_ADDR 8'h83
`define STATUS_CY 7

`define OP_XREAD_DP 8'hE0
`define OP_XWRITE_DP 8'hF0
`define OP_XREAD_RI 7'h71
`define OP_XWRITE_RI 7'h79
`define OP_NIB_XCHG 7'h6B
`define OP_CREAD_DP 8'h93
`define OP_CREAD_PC 8'h83
`define OP_MOV_C_BIT 8'hA2
`define OP_MOV_BIT_C 8'h92
`define OP_CLR_C 8'hC3
`define OP_CLR_BIT 8'hC2
`define OP_SET_C 8'hD3
`define OP_SET_BIT 8'hD2
`define OP_INV_C 8'hB3
`define OP_INV_BIT 8'hB2
`define OP_AND_BIT 8'h82
`define OP_AND_NBIT 8'hB0
`define OP_OR_BIT 8'h72
`define OP_OR_NBIT 8'hA0
`define OP_JMP_CY 8'h40
`define OP_JMP_NCY 8'h50
`define OP_JMP_BIT 8'h20
`define OP_JMP_NBIT 8'h30
`define OP_JMP_TCLR 8'h10
`define OP_LD_ACC 8'h74
`define OP_LD_DP 8'h90
`define OP_LD_DIR 8'h75

`endif

// file: hdl/bit_address_decoder.v
// Direct bit address to byte address and bit position decoder
`timescale 1ns/1ps
`include "bitproc_consts.vh"

module bit_address_decoder (
	input wire [7:0] bit_addr,
	output wire in_ram,
	output wire [7:0] byte_addr,
	output wire [2:0] bit_pos
);
	// Low half hits the bit page of internal RAM, high half the register space
	assign in_ram = ~bit_addr[7];
	assign byte_addr = in_ram ? (`BIT_RAM_BASE + {4'h0, bit_addr[6:3]}) :
		{bit_addr[7:3], 3'b000};
	assign bit_pos = bit_addr[2:0];
endmodule

// file: hdl/bit_move_core.v
// Core executing external data moves, code constant reads and bit operations
`timescale 1ns/1ps
`include "bitproc_consts.vh"

module bit_move_core (
	input wire mclk,
	input wire reset_n,
	output wire [15:0] prog_addr,
	output wire prog_rd,
	input wire [7:0] prog_rdata,
	output wire [15:0] xdata_addr,
	output wire xdata_rd,
	output wire xdata_wr,
	output wire [7:0] xdata_wdata,
	input wire [7:0] xdata_rdata,
	input wire [7:0] port_pins,
	output wire [7:0] port_out,
	output wire [7:0] acc_out,
	output wire carry_out,
	output wire [15:0] pc_out,
	output wire instr_done
);
	localparam [2:0] ST_FETCH = 3'd0;
	localparam [2:0] ST_WAIT = 3'd1;
	localparam [2:0] ST_TAKE = 3'd2;
	localparam [2:0] ST_EXEC = 3'd3;
	localparam [2:0] ST_MEM1 = 3'd4;
	localparam [2:0] ST_MEM2 = 3'd5;

	reg [2:0] state_q;
	reg [15:0] pc_q;
	reg [7:0] acc_q;
	reg [7:0] status_q;
	reg [15:0] dp_q;
	reg [7:0] port_q;
	reg [7:0] iram_q [0:127];
	reg [7:0] op_q;
	reg [7:0] arg1_q;
	reg [7:0] arg2_q;
	reg [1:0] idx_q;
	reg [1:0] len_q;
	reg [7:0] pin_s1_q;
	reg [7:0] pin_s2_q;
	reg [7:0] pin_s3_q;
	reg [7:0] pin_q;
	reg [15:0] prog_addr_q;
	reg prog_rd_q;
	reg [15:0] xdata_addr_q;
	reg [7:0] xdata_wdata_q;
	reg xdata_rd_q;
	reg xdata_wr_q;
	reg done_q;
	integer i;

	// Number of bytes in each supported instruction; unknown codes are one-byte no-ops
	function [1:0] instr_len;
		input [7:0] op;
		begin
			case (op)
				`OP_MOV_C_BIT, `OP_MOV_BIT_C, `OP_CLR_BIT, `OP_SET_BIT, `OP_INV_BIT,
				`OP_AND_BIT, `OP_AND_NBIT, `OP_OR_BIT, `OP_OR_NBIT, `OP_JMP_CY,
				`OP_JMP_NCY, `OP_LD_ACC: instr_len = 2'd2;
				`OP_JMP_BIT, `OP_JMP_NBIT, `OP_JMP_TCLR, `OP_LD_DP,
				`OP_LD_DIR: instr_len = 2'd3;
				default: instr_len = 2'd1;
			endcase
		end
	endfunction

	// Bit addressable register read; port source chosen by caller
	function [7:0] reg_value;
		input [7:0] addr;
		input [7:0] port_src;
		input [7:0] status;
		input [7:0] acc;
		input [15:0] dp;
		begin
			if (addr == `REG_PORT_ADDR) begin
				reg_value = port_src;
			end else if (addr == `REG_STATUS_ADDR) begin
				reg_value = status;
			end else if (addr == `REG_ACC_ADDR) begin
				reg_value = acc;
			end else if (addr == `REG_DP_LO_ADDR) begin
				reg_value = dp[7:0];
			end else if (addr == `REG_DP_HI_ADDR) begin
				reg_value = dp[15:8];
			end else begin
				reg_value = 8'h00;
			end
		end
	endfunction

	function [7:0] put_bit;
		input [7:0] b;
		input [2:0] pos;
		input v;
		begin
			put_bit = b;
			put_bit[pos] = v;
		end
	endfunction

	// Sign-extend offset and add in two's complement
	function [15:0] rel_target;
		input [15:0] pc;
		input [7:0] rel;
		begin
			rel_target = pc + {{8{rel[7]}}, rel};
		end
	endfunction

	wire carry = status_q[`STATUS_CY];
	wire [7:0] status_rd = {status_q[7:1], ^acc_q};
	wire bit_in_ram;
	wire [7:0] bit_byte;
	wire [2:0] bit_pos;

	// Operand byte after the opcode is the direct bit address for the bit instructions
	bit_address_decoder u_bit_dec (
		.bit_addr(arg1_q),
		.in_ram(bit_in_ram),
		.byte_addr(bit_byte),
		.bit_pos(bit_pos)
	);

	wire [7:0] ram_byte = iram_q[bit_byte[6:0]];
	// Tests see pin levels; read-modify-write sees port latches
	wire [7:0] test_byte = bit_in_ram ? ram_byte :
		reg_value(bit_byte, pin_q, status_rd, acc_q, dp_q);
	wire [7:0] rmw_byte = bit_in_ram ? ram_byte :
		reg_value(bit_byte, port_q, status_rd, acc_q, dp_q);
	wire test_bit = test_byte[bit_pos];
	wire rmw_bit = rmw_byte[bit_pos];
	wire [6:0] ri_idx = {2'b00, status_q[4:3], 2'b00, op_q[0]};
	wire [7:0] ri_val = iram_q[ri_idx];
	wire [7:0] nib_byte = iram_q[ri_val[6:0]];
	wire is_xread = (op_q == `OP_XREAD_DP) || (op_q[7:1] == `OP_XREAD_RI);
	wire is_xwrite = (op_q == `OP_XWRITE_DP) || (op_q[7:1] == `OP_XWRITE_RI);
	wire [7:0] branch_rel = (op_q == `OP_JMP_CY || op_q == `OP_JMP_NCY) ? arg1_q : arg2_q;

	reg wr_en;
	reg [7:0] wr_addr;
	reg [7:0] wr_data;
	reg jump;

	always @* begin
		wr_en = 1'b0;
		wr_addr = bit_byte;
		wr_data = rmw_byte;
		jump = 1'b0;
		if (state_q == ST_EXEC) begin
			case (op_q)
				`OP_MOV_BIT_C: begin
					wr_en = 1'b1;
					wr_data = put_bit(rmw_byte, bit_pos, carry);
				end
				`OP_CLR_BIT: begin
					wr_en = 1'b1;
					wr_data = put_bit(rmw_byte, bit_pos, 1'b0);
				end
				`OP_SET_BIT: begin
					wr_en = 1'b1;
					wr_data = put_bit(rmw_byte, bit_pos, 1'b1);
				end
				`OP_INV_BIT: begin
					wr_en = 1'b1;
					wr_data = put_bit(rmw_byte, bit_pos, ~rmw_bit);
				end
				`OP_JMP_CY: jump = carry;
				`OP_JMP_NCY: jump = ~carry;
				`OP_JMP_BIT: jump = test_bit;
				`OP_JMP_NBIT: jump = ~test_bit;
				`OP_JMP_TCLR: begin
					jump = rmw_bit;
					wr_en = rmw_bit;
					wr_data = put_bit(rmw_byte, bit_pos, 1'b0);
				end
				`OP_LD_DIR: begin
					wr_en = 1'b1;
					wr_addr = arg1_q;
					wr_data = arg2_q;
				end
				default: wr_en = 1'b0;
			endcase
		end
	end

	// Three-stage pin synchroniser; a change is accepted when stages two and three agree
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_q <= 8'h00;
			pin_s2_q <= 8'h00;
			pin_s3_q <= 8'h00;
			pin_q <= 8'h00;
		end else begin
			pin_s1_q <= port_pins;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			if (pin_s2_q == pin_s3_q) begin
				pin_q <= pin_s3_q;
			end
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_FETCH;
			pc_q <= `PC_RESET;
			acc_q <= `ACC_RESET;
			status_q <= `STATUS_RESET;
			dp_q <= `DP_RESET;
			port_q <= `PORT_RESET;
			op_q <= 8'h00;
			arg1_q <= 8'h00;
			arg2_q <= 8'h00;
			idx_q <= 2'd0;
			len_q <= 2'd1;
			prog_addr_q <= 16'h0000;
			prog_rd_q <= 1'b0;
			xdata_addr_q <= 16'h0000;
			xdata_wdata_q <= 8'h00;
			xdata_rd_q <= 1'b0;
			xdata_wr_q <= 1'b0;
			done_q <= 1'b0;
			for (i = 0; i < 128; i = i + 1) begin
				iram_q[i] <= `RAM_RESET;
			end
		end else begin
			prog_rd_q <= 1'b0;
			xdata_rd_q <= 1'b0;
			xdata_wr_q <= 1'b0;
			done_q <= 1'b0;
			case (state_q)
				ST_FETCH: begin
					prog_addr_q <= pc_q;
					prog_rd_q <= 1'b1;
					pc_q <= pc_q + 16'h0001;
					state_q <= ST_WAIT;
				end
				ST_WAIT: state_q <= ST_TAKE;
				ST_TAKE: begin
					if (idx_q == 2'd0) begin
						op_q <= prog_rdata;
						len_q <= instr_len(prog_rdata);
						if (instr_len(prog_rdata) == 2'd1) begin
							idx_q <= 2'd0;
							state_q <= ST_EXEC;
						end else begin
							idx_q <= 2'd1;
							state_q <= ST_FETCH;
						end
					end else if (idx_q == 2'd1) begin
						arg1_q <= prog_rdata;
						if (len_q == 2'd2) begin
							idx_q <= 2'd0;
							state_q <= ST_EXEC;
						end else begin
							idx_q <= 2'd2;
							state_q <= ST_FETCH;
						end
					end else begin
						arg2_q <= prog_rdata;
						idx_q <= 2'd0;
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state_q <= ST_FETCH;
					done_q <= 1'b1;
					case (op_q)
						`OP_MOV_C_BIT: status_q[`STATUS_CY] <= test_bit;
						`OP_CLR_C: status_q[`STATUS_CY] <= 1'b0;
						`OP_SET_C: status_q[`STATUS_CY] <= 1'b1;
						`OP_INV_C: status_q[`STATUS_CY] <= ~carry;
						`OP_AND_BIT: status_q[`STATUS_CY] <= carry & test_bit;
						`OP_AND_NBIT: status_q[`STATUS_CY] <= carry & ~test_bit;
						`OP_OR_BIT: status_q[`STATUS_CY] <= carry | test_bit;
						`OP_OR_NBIT: status_q[`STATUS_CY] <= carry | ~test_bit;
						`OP_XREAD_DP, `OP_XWRITE_DP: begin
							xdata_addr_q <= dp_q;
							xdata_rd_q <= is_xread;
							xdata_wr_q <= is_xwrite;
							xdata_wdata_q <= acc_q;
							done_q <= 1'b0;
							state_q <= ST_MEM1;
						end
						`OP_CREAD_DP: begin
							prog_addr_q <= dp_q + {8'h00, acc_q};
							prog_rd_q <= 1'b1;
							done_q <= 1'b0;
							state_q <= ST_MEM1;
						end
						`OP_CREAD_PC: begin
							prog_addr_q <= pc_q + {8'h00, acc_q};
							prog_rd_q <= 1'b1;
							done_q <= 1'b0;
							state_q <= ST_MEM1;
						end
						`OP_LD_ACC: acc_q <= arg1_q;
						`OP_LD_DP: dp_q <= {arg1_q, arg2_q};
						default: begin
							if (is_xread || is_xwrite) begin
								xdata_addr_q <= {8'h00, ri_val};
								xdata_rd_q <= is_xread;
								xdata_wr_q <= is_xwrite;
								xdata_wdata_q <= acc_q;
								done_q <= 1'b0;
								state_q <= ST_MEM1;
							end else if (op_q[7:1] == `OP_NIB_XCHG) begin
								acc_q <= {acc_q[7:4], nib_byte[3:0]};
								iram_q[ri_val[6:0]] <= {nib_byte[7:4], acc_q[3:0]};
							end
							// Bit writes, direct byte loads and jumps are applied below; any other code, a carry exclusive-OR included, is a no-op
						end
					endcase
					if (jump) begin
						pc_q <= rel_target(pc_q, branch_rel);
					end
					if (wr_en) begin
						if (!wr_addr[7]) begin
							iram_q[wr_addr[6:0]] <= wr_data;
						end else if (wr_addr == `REG_PORT_ADDR) begin
							port_q <= wr_data;
						end else if (wr_addr == `REG_STATUS_ADDR) begin
							status_q <= wr_data;
						end else if (wr_addr == `REG_ACC_ADDR) begin
							acc_q <= wr_data;
						end else if (wr_addr == `REG_DP_LO_ADDR) begin
							dp_q[7:0] <= wr_data;
						end else if (wr_addr == `REG_DP_HI_ADDR) begin
							dp_q[15:8] <= wr_data;
						end
					end
				end
				// First transfer cycle: the strobe is seen by the memory
				ST_MEM1: state_q <= ST_MEM2;
				// Second transfer cycle: no code fetch is issued here
				ST_MEM2: begin
					if (is_xread) begin
						acc_q <= xdata_rdata;
					end else if (op_q == `OP_CREAD_DP || op_q == `OP_CREAD_PC) begin
						acc_q <= prog_rdata;
					end
					done_q <= 1'b1;
					state_q <= ST_FETCH;
				end
				default: state_q <= ST_FETCH;
			endcase
		end
	end

	assign prog_addr = prog_addr_q;
	assign prog_rd = prog_rd_q;
	assign xdata_addr = xdata_addr_q;
	assign xdata_rd = xdata_rd_q;
	assign xdata_wr = xdata_wr_q;
	assign xdata_wdata = xdata_wdata_q;
	assign port_out = port_q;
	assign acc_out = acc_q;
	assign carry_out = carry;
	assign pc_out = pc_q;
	assign instr_done = done_q;
endmodule

// file: sim/code_xdata_model.sv
// Program memory and external data memory seen by the core
`timescale 1ns/1ps
module code_xdata_model (
	input wire mclk,
	input wire [15:0] prog_addr,
	input wire prog_rd,
	output logic [7:0] prog_rdata,
	input wire [15:0] xdata_addr,
	input wire xdata_rd,
	input wire xdata_wr,
	input wire [7:0] xdata_wdata,
	output logic [7:0] xdata_rdata
);
	logic [7:0] code_mem [0:65535];
	logic [7:0] xram [0:65535];
	initial begin
		prog_rdata = 8'h00;
		xdata_rdata = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			code_mem[i] = 8'h00;
			xram[i] = 8'h00;
		end
	end
	// Read data lasts one cycle, then the bus toggles so stale bytes never pass
	always @(posedge mclk) begin
		if (prog_rd)
			prog_rdata <= code_mem[prog_addr];
		else
			prog_rdata <= ~prog_rdata;
		if (xdata_rd)
			xdata_rdata <= xram[xdata_addr];
		else
			xdata_rdata <= ~xdata_rdata;
		if (xdata_wr)
			xram[xdata_addr] <= xdata_wdata;
	end
endmodule

// file: sim/bit_move_core_assertions.sv
// Port-level checker for the bit processor and memory move core
`timescale 1ns/1ps
module bit_move_core_assertions (
	input logic mclk,
	input logic reset_n,
	input logic prog_rd,
	input logic [15:0] xdata_addr,
	input logic xdata_rd,
	input logic xdata_wr,
	input logic [7:0] xdata_wdata,
	input logic [7:0] xdata_rdata,
	input logic [7:0] port_out,
	input logic [7:0] acc_out,
	input logic instr_done
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	AST_XRD_NO_FETCH: assert property (xdata_rd |-> !prog_rd ##1 !prog_rd)
		else $error("code fetch during external read");
	AST_XWR_NO_FETCH: assert property (xdata_wr |-> !prog_rd ##1 !prog_rd)
		else $error("code fetch during external write");
	AST_XRW_EXCL: assert property (!(xdata_rd && xdata_wr))
		else $error("read and write strobes together");
	AST_XRD_TO_ACC: assert property (xdata_rd |-> ##2 (instr_done && acc_out == $past(xdata_rdata)))
		else $error("external read data not in accumulator");
	AST_XWR_FROM_ACC: assert property (xdata_wr |-> xdata_wdata == acc_out)
		else $error("external write data is not the accumulator");
	AST_XADDR_HOLD: assert property ((xdata_rd || xdata_wr) |=> $stable(xdata_addr) [*2])
		else $error("external address moved during transfer");
	AST_PORT_ONE_BIT: assert property ((port_out != $past(port_out)) |-> $onehot(port_out ^ $past(port_out)))
		else $error("more than one port latch changed");
	AST_PORT_AT_RETIRE: assert property ($changed(port_out) |-> instr_done)
		else $error("port latch changed outside retire");
	cover property (xdata_rd);
	cover property (xdata_wr);
	cover property ($changed(port_out));
endmodule

// file: sim/test_bit_move_core.sv
// Self-checking bench running a bit and move program on the core
`timescale 1ns/1ps
module test_bit_move_core;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] port_pins = 8'h00;
	wire [15:0] prog_addr, xdata_addr, pc_out;
	wire prog_rd, xdata_rd, xdata_wr, carry_out, instr_done;
	wire [7:0] prog_rdata, xdata_wdata, xdata_rdata, port_out, acc_out;
	int miscompares = 0;
	int tests_run = 0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		#1 port_pins = 8'($urandom);
	end
	bit_move_core DUT (.mclk(mclk), .reset_n(reset_n), .prog_addr(prog_addr),
		.prog_rd(prog_rd), .prog_rdata(prog_rdata), .xdata_addr(xdata_addr),
		.xdata_rd(xdata_rd), .xdata_wr(xdata_wr), .xdata_wdata(xdata_wdata),
		.xdata_rdata(xdata_rdata), .port_pins(port_pins), .port_out(port_out),
		.acc_out(acc_out), .carry_out(carry_out), .pc_out(pc_out), .instr_done(instr_done));
	code_xdata_model mem (.mclk(mclk), .prog_addr(prog_addr), .prog_rd(prog_rd),
		.prog_rdata(prog_rdata), .xdata_addr(xdata_addr), .xdata_rd(xdata_rd),
		.xdata_wr(xdata_wr), .xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata));
	function logic exp_carry(input logic [7:0] r);
		logic c;
		c = r[7] & r[0];
		c = c | r[1];
		c = c & ~r[2];
		c = c | ~r[3];
		return ~c;
	endfunction
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Program: table reads, external moves, carry logic, port bits, branches,
	// RAM bit page, low nibble exchange and status bit tests
	task run_program(input logic [7:0] r);
		logic [7:0] p [0:73];
		logic c;
		int n;
		p = '{8'h74, 8'h00, 8'h90, 8'h12, 8'h34, 8'hF0, 8'h74, 8'h05, 8'h93, 8'hF2,
			8'hE0, 8'hA2, 8'hE7, 8'h82, 8'hE0, 8'h72, 8'hE1, 8'hB0, 8'hE2, 8'hA0,
			8'hE3, 8'hB3, 8'h92, 8'h97, 8'h40, 8'h02, 8'hC2, 8'h94, 8'h10, 8'h90,
			8'h02, 8'hC2, 8'h95, 8'h10, 8'h90, 8'h02, 8'hC2, 8'h96, 8'h74, 8'h01,
			8'h83, 8'h00, 8'hA5, 8'h75, 8'h21, 8'h00, 8'hD2, 8'h0F, 8'h75, 8'h00,
			8'h21, 8'hD6, 8'h20, 8'h0F, 8'h02, 8'h74, 8'hEE, 8'h30, 8'h09, 8'h02,
			8'h74, 8'hEE, 8'h92, 8'h00, 8'h40, 8'h01, 8'hD3, 8'h20, 8'hD7, 8'h02,
			8'h74, 8'hEE, 8'hA2, 8'h00};
		p[1] = r;
		p[45] = r;
		for (n = 0; n < 74; n++)
			mem.code_mem[n] = p[n];
		mem.code_mem[16'h1239] = r ^ 8'h5A;
		@(posedge mclk);
		#1 reset_n = 1'b0;
		repeat (5) @(posedge mclk);
		#1 reset_n = 1'b1;
		n = 0;
		while (pc_out !== 16'h0050 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		#1;
		c = exp_carry(r);
		check(n < 2000, 16'h0001);
		check(acc_out, {8'h00, 4'hA, r[3:0]});
		check(DUT.iram_q[33], {8'h00, 1'b1, r[6:4], 4'h5});
		check(DUT.iram_q[32], {15'h0000, c});
		check(carry_out, c);
		check(port_out, {c, 1'b0, 1'b1, c, 3'b111, 1'b0});
		check(mem.xram[16'h1234], r);
		check(mem.xram[16'h0000], r ^ 8'h5A);
	endtask
	initial begin
		void'($urandom(32'hC4E9));
		run_program(8'h00);
		run_program(8'hFF);
		repeat (6) run_program(8'($urandom));
		summarize;
	end
	initial begin
		#100000;
		miscompares++;
		summarize;
	end
endmodule
bind bit_move_core bit_move_core_assertions chk (.mclk(mclk), .reset_n(reset_n),
	.prog_rd(prog_rd), .xdata_addr(xdata_addr), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
	.xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata), .port_out(port_out),
	.acc_out(acc_out), .instr_done(instr_done));
